/* hw/flash_cfg_params.svh */
`ifndef FLASH_CFG_PARAMS_SVH
`define FLASH_CFG_PARAMS_SVH

// =====================================================
// Command opcodes
`define OP_WRITE_SR1 8'h01
`define OP_WRITE_SR2 8'h31
`define OP_WRITE_SR3 8'h11
`define OP_WRITE_SR4 8'h71
`define OP_READ_SR3 8'h15
`define OP_READ_SR4 8'h45
`define OP_BLOCK_LOCK 8'h36
`define OP_BLOCK_UNLOCK 8'h39
`define OP_POWERDOWN 8'hB9
`define OP_ULTRA_POWERDOWN 8'h79
`define OP_WAKE 8'hAB
`define OP_PROGRAM 8'h02

// =====================================================
// Field positions, pin and protect register
`define HOLD_RESET_SEL_BIT 7
`define DRIVE_LEVEL_LSB 5
`define PROTECT_SCHEME_BIT 2
// Field positions, power and program register
`define POWERDOWN_DEPTH_BIT 7
`define SEQ_PROGRAM_BIT 6

// =====================================================
// Reset values
`define HOLD_RESET_SEL_RST 1'h0
`define DRIVE_LEVEL_RST 2'h1
`define PROTECT_SCHEME_RST 1'h0
`define POWERDOWN_DEPTH_RST 1'h0
`define SEQ_PROGRAM_RST 1'h0
`define BLOCK_LOCK_RST 1'h1

// =====================================================
// Block protection geometry
`define NUM_BLOCKS 32
`define BLOCK_INDEX_LSB 16
`define BLOCK_INDEX_W 5

// Bytes in an address phase
`define ADDR_BYTES 3'h3

`endif

/* hw/flash_cfg_pkg.sv */
package flash_cfg_pkg;

  // =====================================================
  // Types
  typedef enum logic [1:0] {
    DRIVE_RESERVED,
    DRIVE_FULL,
    DRIVE_TWO_THIRDS,
    DRIVE_ONE_THIRD
  } drive_level_t;

  typedef enum logic [1:0] {
    PD_AWAKE,
    PD_DEEP,
    PD_ULTRA
  } pd_state_t;

  typedef struct packed {
    logic hold_enable;
    logic reset_enable;
    logic data_only;
  } pin_role_t;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } link_byte_t;

  typedef struct packed {
    logic answer;
    logic [7:0] pin_cfg;
    logic [7:0] power_cfg;
  } readback_t;

endpackage : flash_cfg_pkg

/* hw/spi_cmd_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg_params.svh"

module spi_cmd_shifter (
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic sys_rst,
  input wire flash_cfg_pkg::readback_t readback,
  output var flash_cfg_pkg::link_byte_t rx_byte,
  output logic rx_toggle,
  output logic miso,
  output logic miso_oe
);

  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic first_pending;
  logic reading;
  logic read_power;
  logic [7:0] tx;
  logic [7:0] opcode_in;

  assign opcode_in = {shift, mosi};

  // =====================================================
  // Receive shifter, cleared by every deselect
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      first_pending <= 1'b1;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shift <= {shift[5:0], mosi};
      if (bit_cnt == 3'h7) begin
        first_pending <= 1'b0;
      end
    end
  end

  // Held for a whole byte time, so the core can sample it after the toggle
  always_ff @(posedge spi_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_byte <= '0;
      rx_toggle <= 1'b0;
    end else if (bit_cnt == 3'h7) begin
      rx_byte <= '{first: first_pending, data: opcode_in};
      rx_toggle <= ~rx_toggle;
    end
  end

  // =====================================================
  // Read commands, answered only while the core is awake
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      reading <= 1'b0;
      read_power <= 1'b0;
    end else if (bit_cnt == 3'h7 && first_pending) begin
      reading <= readback.answer &&
        (opcode_in == `OP_READ_SR3 || opcode_in == `OP_READ_SR4);
      read_power <= (opcode_in == `OP_READ_SR4);
    end
  end

  // Readback is frozen by the core while a frame is open
  always_ff @(negedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      tx <= 8'h00;
    end else if (bit_cnt == 3'h0) begin
      tx <= read_power ? readback.power_cfg : readback.pin_cfg;
    end else begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  assign miso = tx[7];
  assign miso_oe = reading & ~cs_n;

endmodule : spi_cmd_shifter

`default_nettype wire

/* hw/flash_config_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg_params.svh"


module flash_config_status_regs (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic quad_enable_bit,
  input wire logic status_protect_low,
  input wire logic status_protect_high,
  input wire logic write_enable_latch,
  input wire logic seq_program_mode,
  output var flash_cfg_pkg::pin_role_t pin_role,
  output var flash_cfg_pkg::drive_level_t output_drive_level,
  output logic region_protect_active,
  output logic [`NUM_BLOCKS-1:0] block_locks,
  output var flash_cfg_pkg::pd_state_t powerdown_state,
  output logic keep_buffer,
  output logic sequential_program_flag,
  output logic prog_byte_valid,
  output logic [23:0] prog_addr,
  output logic [7:0] prog_byte
);

  // =====================================================
  // Declarations
  flash_cfg_pkg::link_byte_t rx_byte;
  flash_cfg_pkg::readback_t readback;
  logic rx_toggle;
  logic tg_s1;
  logic tg_s2;
  logic tg_s3;
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic cs_s4;
  logic byte_strobe;
  logic frame_end;
  logic frame_idle;
  logic [2:0] byte_idx;
  logic [2:0] cur_idx;
  logic [7:0] opcode;
  logic [7:0] data_byte;
  logic [23:0] cmd_addr;
  logic [23:0] run_addr;
  logic seq_running;
  logic hold_reset_sel;
  logic [1:0] drive_level;
  logic protect_scheme_select;
  logic powerdown_depth_select;
  logic awake;
  logic status_write_ok;
  logic [`BLOCK_INDEX_W-1:0] block_index;
  logic [7:0] pin_cfg_value;
  logic [7:0] power_cfg_value;

  // =====================================================
  // Functions
  function automatic logic [2:0] next_index(input logic first, input logic [2:0] idx);
    logic [2:0] nxt;
    nxt = 3'h0;
    if (!first) begin
      nxt = (idx == 3'h7) ? idx : idx + 3'h1;
    end
    return nxt;
  endfunction : next_index

  // =====================================================
  // Link side
  spi_cmd_shifter link (
    .spi_clk(spi_clk),
    .cs_n(cs_n),
    .mosi(mosi),
    .sys_rst(sys_rst),
    .readback(readback),
    .rx_byte(rx_byte),
    .rx_toggle(rx_toggle),
    .miso(miso),
    .miso_oe(miso_oe)
  );

  // =====================================================
  // Crossings into the core domain
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end else begin
      tg_s1 <= rx_toggle;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end

  // Deselect is seen one stage later than the last byte, so that byte is in
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      cs_s4 <= 1'b1;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      cs_s4 <= cs_s3;
    end
  end

  assign byte_strobe = tg_s2 ^ tg_s3;
  assign frame_end = cs_s3 & ~cs_s4;
  assign frame_idle = cs_s2 & cs_s3;
  assign cur_idx = next_index(rx_byte.first, byte_idx - 3'h1);
  assign awake = (powerdown_state == flash_cfg_pkg::PD_AWAKE);

  // =====================================================
  // Frame collection
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_idx <= 3'h0;
      opcode <= 8'h00;
      data_byte <= 8'h00;
      cmd_addr <= 24'h000000;
    end else if (frame_end) begin
      byte_idx <= 3'h0;
      opcode <= 8'h00;
    end else if (byte_strobe) begin
      byte_idx <= next_index(rx_byte.first, byte_idx) + (rx_byte.first ? 3'h1 : 3'h0);
      if (rx_byte.first) begin
        opcode <= rx_byte.data;
      end
      if (cur_idx == 3'h1) begin
        data_byte <= rx_byte.data;
      end
      if (cur_idx != 3'h0 && cur_idx <= `ADDR_BYTES) begin
        cmd_addr <= {cmd_addr[15:0], rx_byte.data};
      end
    end
  end

  // =====================================================
  // Status register write gate
  assign status_write_ok = awake && !status_protect_low && !status_protect_high && write_enable_latch;

  // Pin and protect configuration
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_reset_sel <= `HOLD_RESET_SEL_RST;
      drive_level <= `DRIVE_LEVEL_RST;
      protect_scheme_select <= `PROTECT_SCHEME_RST;
    end else if (frame_end && opcode == `OP_WRITE_SR3 && byte_idx >= 3'h2 && status_write_ok) begin
      // Only the three defined fields are taken; bits 4:3 and 1:0 drop
      hold_reset_sel <= data_byte[`HOLD_RESET_SEL_BIT];
      drive_level <= data_byte[`DRIVE_LEVEL_LSB +: 2];
      protect_scheme_select <= data_byte[`PROTECT_SCHEME_BIT];
    end
  end

  // Power and program configuration
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      powerdown_depth_select <= `POWERDOWN_DEPTH_RST;
    end else if (frame_end && opcode == `OP_WRITE_SR4 && byte_idx >= 3'h2 && status_write_ok) begin
      powerdown_depth_select <= data_byte[`POWERDOWN_DEPTH_BIT];
    end
  end

  // Mode flag follows the program engine; host writes never reach it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sequential_program_flag <= `SEQ_PROGRAM_RST;
    end else begin
      sequential_program_flag <= seq_program_mode;
    end
  end

  // =====================================================
  // Pin role and drive strength
  always_comb begin
    pin_role.data_only = quad_enable_bit;
    pin_role.hold_enable = !quad_enable_bit && !hold_reset_sel;
    pin_role.reset_enable = !quad_enable_bit && hold_reset_sel;
  end

  assign output_drive_level = flash_cfg_pkg::drive_level_t'(drive_level);
  assign region_protect_active = !protect_scheme_select;

  // =====================================================
  // Per-block locks
  assign block_index = cmd_addr[`BLOCK_INDEX_LSB +: `BLOCK_INDEX_W];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      block_locks <= {`NUM_BLOCKS{`BLOCK_LOCK_RST}};
    end else if (frame_end && awake && protect_scheme_select && byte_idx > `ADDR_BYTES) begin
      if (opcode == `OP_BLOCK_LOCK) begin
        block_locks[block_index] <= 1'b1;
      end else if (opcode == `OP_BLOCK_UNLOCK) begin
        block_locks[block_index] <= 1'b0;
      end
    end
  end

  // =====================================================
  // Power-down depth
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      powerdown_state <= flash_cfg_pkg::PD_AWAKE;
    end else if (frame_end) begin
      case (powerdown_state)
        flash_cfg_pkg::PD_AWAKE: begin
          if (opcode == `OP_ULTRA_POWERDOWN) begin
            powerdown_state <= flash_cfg_pkg::PD_ULTRA;
          end else if (opcode == `OP_POWERDOWN) begin
            powerdown_state <= powerdown_depth_select ? flash_cfg_pkg::PD_DEEP : flash_cfg_pkg::PD_ULTRA;
          end
        end
        flash_cfg_pkg::PD_DEEP, flash_cfg_pkg::PD_ULTRA: begin
          // An empty frame also ends here, which must not wake the part
          if (opcode == `OP_WAKE) begin
            powerdown_state <= flash_cfg_pkg::PD_AWAKE;
          end
        end
        default: begin
          powerdown_state <= flash_cfg_pkg::PD_AWAKE;
        end
      endcase
    end
  end

  assign keep_buffer = (powerdown_state == flash_cfg_pkg::PD_DEEP);

  // =====================================================
  // Program data stream with running address
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_byte_valid <= 1'b0;
      prog_byte <= 8'h00;
      prog_addr <= 24'h000000;
      run_addr <= 24'h000000;
    end else begin
      prog_byte_valid <= 1'b0;
      if (byte_strobe && !rx_byte.first && awake && opcode == `OP_PROGRAM) begin
        if (!seq_running && cur_idx <= `ADDR_BYTES) begin
          run_addr <= {run_addr[15:0], rx_byte.data};
        end else begin
          prog_byte_valid <= 1'b1;
          prog_byte <= rx_byte.data;
          prog_addr <= run_addr;
          run_addr <= run_addr + 24'h000001;
        end
      end
    end
  end

  // After one addressed transfer in sequential mode, later ones skip the address
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_running <= 1'b0;
    end else if (!sequential_program_flag) begin
      seq_running <= 1'b0;
    end else if (frame_end && awake && opcode == `OP_PROGRAM && byte_idx > `ADDR_BYTES) begin
      seq_running <= 1'b1;
    end
  end

  // =====================================================
  // Readback, frozen while a frame is open so the link sees stable bits
  always_comb begin
    pin_cfg_value = 8'h00;
    pin_cfg_value[`HOLD_RESET_SEL_BIT] = hold_reset_sel;
    pin_cfg_value[`DRIVE_LEVEL_LSB +: 2] = drive_level;
    pin_cfg_value[`PROTECT_SCHEME_BIT] = protect_scheme_select;
    power_cfg_value = 8'h00;
    power_cfg_value[`POWERDOWN_DEPTH_BIT] = powerdown_depth_select;
    power_cfg_value[`SEQ_PROGRAM_BIT] = sequential_program_flag;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      readback <= '{answer: 1'b1, pin_cfg: 8'h20, power_cfg: 8'h00};
    end else if (frame_idle) begin
      readback <= '{answer: awake, pin_cfg: pin_cfg_value, power_cfg: power_cfg_value};
    end
  end

endmodule : flash_config_status_regs

`default_nettype wire

/* tb/flash_config_status_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg_params.svh"

module flash_config_status_regs_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic quad_enable_bit,
  input wire logic status_protect_low,
  input wire logic status_protect_high,
  input wire logic write_enable_latch,
  input wire logic seq_program_mode,
  input wire flash_cfg_pkg::pin_role_t pin_role,
  input wire flash_cfg_pkg::drive_level_t output_drive_level,
  input wire logic region_protect_active,
  input wire logic [`NUM_BLOCKS-1:0] block_locks,
  input wire flash_cfg_pkg::pd_state_t powerdown_state,
  input wire logic keep_buffer,
  input wire logic sequential_program_flag,
  input wire logic prog_byte_valid,
  input wire logic [23:0] prog_addr,
  input wire logic [7:0] prog_byte
);
  // ==========
  // Properties
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_qe_data_only: assert property (quad_enable_bit |-> pin_role == 3'h1)
    else $error("Shared pin not data only");
  a_hold_or_reset: assert property (!quad_enable_bit |-> pin_role == 3'h4 || pin_role == 3'h2)
    else $error("Shared pin lacks a single role");
  a_buffer_depth: assert property (keep_buffer == (powerdown_state == flash_cfg_pkg::PD_DEEP))
    else $error("Buffer keep does not match depth");
  // Frame effects land after deselect, so a state change inside a frame is a fault
  a_pd_frame_end: assert property ($changed(powerdown_state) |-> cs_n && $past(cs_n, 3))
    else $error("Power state moved inside a frame");
  a_seq_mirror: assert property ($changed(seq_program_mode) |=> sequential_program_flag == $past(seq_program_mode))
    else $error("Sequential flag did not follow mode");
  a_reset_default: assert property ($fell(sys_rst) |-> output_drive_level == flash_cfg_pkg::DRIVE_FULL
    && region_protect_active && &block_locks && powerdown_state == flash_cfg_pkg::PD_AWAKE && !sequential_program_flag)
    else $error("Wrong value after reset");
  a_lock_scheme: assert property ($changed(block_locks) |-> !region_protect_active)
    else $error("Lock bits moved in region scheme");
  a_write_guard: assert property ($changed(output_drive_level) |-> write_enable_latch && !status_protect_low
    && !status_protect_high)
    else $error("Config changed without write permission");
  a_prog_pulse: assert property (prog_byte_valid |=> !prog_byte_valid)
    else $error("Program strobe longer than one cycle");
  a_sleep_no_read: assert property (powerdown_state != flash_cfg_pkg::PD_AWAKE |-> !miso_oe)
    else $error("Read answered during power-down");
endmodule : flash_config_status_regs_asserts

bind flash_config_status_regs flash_config_status_regs_asserts flash_config_status_regs_asserts_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
  .miso_oe(miso_oe), .quad_enable_bit(quad_enable_bit), .status_protect_low(status_protect_low),
  .status_protect_high(status_protect_high), .write_enable_latch(write_enable_latch),
  .seq_program_mode(seq_program_mode), .pin_role(pin_role), .output_drive_level(output_drive_level),
  .region_protect_active(region_protect_active), .block_locks(block_locks), .powerdown_state(powerdown_state),
  .keep_buffer(keep_buffer), .sequential_program_flag(sequential_program_flag),
  .prog_byte_valid(prog_byte_valid), .prog_addr(prog_addr), .prog_byte(prog_byte)
);

`default_nettype wire

/* tb/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  output logic spi_clk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // ==========
  // Link clock of 64 ns, running only inside frames
  localparam int HALF = 32;

  initial begin
    spi_clk = 1'h0;
    // Scheduled late so the shifter's asynchronous clear sees this first rising edge
    cs_n <= 1'h1;
    mosi = 1'h0;
  end

  // Bytes leave MSB first from the top of tx; rx keeps the last byte seen
  task automatic xfer(input int n, input logic [39:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    #7;
    cs_n = 1'h0;
    for (int i = 0; i < n * 8; i++) begin
      mosi = tx[39 - i];
      #(HALF);
      spi_clk = 1'h1;
      rx = {rx[6:0], miso};
      #(HALF);
      spi_clk = 1'h0;
    end
    #(HALF);
    cs_n = 1'h1;
    // Released line must not keep showing the last bit
    mosi = ~mosi;
    // Gap well past the minimum so frame effects land before the next request
    #150;
  endtask : xfer
endmodule : spi_host_model

`default_nettype wire

/* tb/flash_config_status_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg_params.svh"

module flash_config_status_regs_bench;
  logic core_clk, sys_rst, spi_clk, cs_n, mosi, miso, miso_oe, oe_seen;
  logic quad_enable_bit, status_protect_low, status_protect_high, write_enable_latch, seq_program_mode;
  flash_cfg_pkg::pin_role_t pin_role;
  flash_cfg_pkg::drive_level_t output_drive_level;
  flash_cfg_pkg::pd_state_t powerdown_state;
  logic region_protect_active, keep_buffer, sequential_program_flag, prog_byte_valid;
  logic [`NUM_BLOCKS-1:0] block_locks, locks_exp;
  logic [23:0] prog_addr, last_addr;
  logic [7:0] prog_byte, last_byte, rd;
  int num_errors, checked, cycles;

  flash_config_status_regs flash_config_status_regs_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .quad_enable_bit(quad_enable_bit), .status_protect_low(status_protect_low),
    .status_protect_high(status_protect_high), .write_enable_latch(write_enable_latch),
    .seq_program_mode(seq_program_mode), .pin_role(pin_role), .output_drive_level(output_drive_level),
    .region_protect_active(region_protect_active), .block_locks(block_locks), .powerdown_state(powerdown_state),
    .keep_buffer(keep_buffer), .sequential_program_flag(sequential_program_flag),
    .prog_byte_valid(prog_byte_valid), .prog_addr(prog_addr), .prog_byte(prog_byte)
  );

  spi_host_model spi_host_model_inst (.spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========
  // Monitor and timeout
  always @(posedge core_clk) begin
    cycles++;
    if (miso_oe === 1'h1) oe_seen = 1'h1;
    if (prog_byte_valid === 1'h1) begin
      last_addr = prog_addr;
      last_byte = prog_byte;
    end
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // ==========
  // Helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic frame(input int n, input logic [39:0] tx);
    spi_host_model_inst.xfer(n, tx, rd);
  endtask : frame

  task automatic set_in(input logic [3:0] v);
    @(negedge core_clk);
    {write_enable_latch, status_protect_low, status_protect_high, quad_enable_bit} = v;
  endtask : set_in

  task automatic do_reset();
    @(negedge core_clk);
    seq_program_mode = 1'h0;
    sys_rst = 1'h1;
    repeat (16) @(negedge core_clk);
    sys_rst = 1'h0;
    repeat (2) @(negedge core_clk);
  endtask : do_reset

  task automatic test_done();
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // ==========
  // Scenarios
  task automatic t_defaults();
    check("pin_role", pin_role, 32'h4);
    check("drive", output_drive_level, 32'h1);
    check("region", region_protect_active, 32'h1);
    check("locks", block_locks, 32'hFFFFFFFF);
    check("pd", {keep_buffer, powerdown_state}, 32'h0);
    check("seq_flag", sequential_program_flag, 32'h0);
    oe_seen = 1'h0;
    frame(2, {8'h15, 32'h0});
    check("pin_cfg", rd, 32'h20);
    check("read_oe", oe_seen, 32'h1);
    check("oe_idle", miso_oe, 32'h0);
    frame(2, {8'h45, 32'h0});
    check("power_cfg", rd, 32'h0);
  endtask : t_defaults

  task automatic t_pin_cfg();
    set_in(4'h8);
    frame(2, {8'h11, 8'hFF, 24'h0});
    check("pin_role", pin_role, 32'h2);
    check("region", region_protect_active, 32'h0);
    frame(2, {8'h15, 32'h0});
    check("pin_cfg", rd, 32'hE4);
    set_in(4'h9);
    @(negedge core_clk);
    check("pin_role", pin_role, 32'h1);
    set_in(4'h8);
    for (int i = 0; i < 4; i++) begin
      frame(2, {8'h11, 1'h0, i[1:0], 5'h04, 24'h0});
      check("drive", output_drive_level, i);
    end
  endtask : t_pin_cfg

  task automatic t_guard();
    logic [3:0] g [3] = '{4'h0, 4'hC, 4'hA};
    foreach (g[k]) begin
      set_in(g[k]);
      frame(2, {8'h11, 8'h24, 24'h0});
      check("drive", output_drive_level, 32'h3);
    end
    set_in(4'h8);
  endtask : t_guard

  task automatic t_locks();
    locks_exp = '1;
    frame(4, {8'h39, 24'h050000, 8'h0});
    locks_exp[5] = 1'h0;
    check("locks", block_locks, locks_exp);
    frame(4, {8'h39, 24'h1F0000, 8'h0});
    locks_exp[31] = 1'h0;
    check("locks", block_locks, locks_exp);
    frame(4, {8'h36, 24'h050000, 8'h0});
    locks_exp[5] = 1'h1;
    // Short address must be refused
    frame(3, {8'h39, 16'h0300, 16'h0});
    check("locks", block_locks, locks_exp);
    frame(2, {8'h11, 8'h60, 24'h0});
    check("region", region_protect_active, 32'h1);
    frame(4, {8'h39, 24'h030000, 8'h0});
    check("locks", block_locks, locks_exp);
  endtask : t_locks

  task automatic t_power();
    frame(2, {8'h71, 8'h00, 24'h0});
    frame(1, {8'hB9, 32'h0});
    check("pd", {keep_buffer, powerdown_state}, 32'h2);
    oe_seen = 1'h0;
    frame(2, {8'h15, 32'h0});
    frame(0, 40'h0);
    check("read_oe", oe_seen, 32'h0);
    check("pd", {keep_buffer, powerdown_state}, 32'h2);
    frame(1, {8'hAB, 32'h0});
    check("pd", {keep_buffer, powerdown_state}, 32'h0);
    frame(1, {8'h79, 32'h0});
    check("pd", {keep_buffer, powerdown_state}, 32'h2);
    frame(1, {8'hAB, 32'h0});
    frame(2, {8'h71, 8'hC0, 24'h0});
    frame(2, {8'h45, 32'h0});
    check("power_cfg", rd, 32'h80);
    frame(1, {8'hB9, 32'h0});
    check("pd", {keep_buffer, powerdown_state}, 32'h5);
    frame(1, {8'hAB, 32'h0});
    check("pd", {keep_buffer, powerdown_state}, 32'h0);
  endtask : t_power

  task automatic t_seq();
    @(negedge core_clk);
    seq_program_mode = 1'h1;
    repeat (2) @(negedge core_clk);
    check("seq_flag", sequential_program_flag, 32'h1);
    frame(5, {8'h02, 24'h000100, 8'hAA});
    check("prog", {last_addr, last_byte}, 32'h000100AA);
    frame(2, {8'h02, 8'h55, 24'h0});
    check("prog", {last_addr, last_byte}, 32'h00010155);
    @(negedge core_clk);
    seq_program_mode = 1'h0;
    repeat (2) @(negedge core_clk);
    check("seq_flag", sequential_program_flag, 32'h0);
    // Byte mode again: every program frame carries its own address
    frame(5, {8'h02, 24'h000200, 8'h33});
    check("prog", {last_addr, last_byte}, 32'h00020033);
  endtask : t_seq

  initial begin
    // Scheduled late so the link-side flops see this first rising edge
    sys_rst <= 1'h1;
    {write_enable_latch, status_protect_low, status_protect_high, quad_enable_bit} = 4'h0;
    seq_program_mode = 1'h0;
    oe_seen = 1'h0;
    num_errors = 0;
    checked = 0;
    cycles = 0;
    do_reset();
    t_defaults();
    t_pin_cfg();
    t_guard();
    t_locks();
    t_power();
    t_seq();
    do_reset();
    t_defaults();
    test_done();
  end
endmodule : flash_config_status_regs_bench

`default_nettype wire
